//--- ipa_arb.sv
`timescale 1ns/1ps
module ipa_arb #(
  parameter int NUM_SRC = ipa_pkg::NUM_SRC,
  parameter int IDX_W = $clog2(ipa_pkg::NUM_SRC)
) (
  input wire logic [ipa_pkg::CTL_W-1:0] ctrl [NUM_SRC],
  output logic win_valid,
  output logic [IDX_W-1:0] win_idx,
  output logic [ipa_pkg::LVL_W-1:0] win_lvl,
  output logic [ipa_pkg::GRP_W-1:0] win_grp,
  output logic any_pend
);
  import ipa_pkg::*;

  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] pend;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      assign pend[g] = ctrl[g][CTL_FLAG] & ctrl[g][CTL_EN];
      assign elig[g] = pend[g] & (ctrl[g][CTL_LVL_HI:CTL_LVL_LO] != LVL_ZERO);
    end
  endgenerate

  assign any_pend = |pend;

  // Level sits above group in the key, so one unsigned compare does both levels.
  // On equal keys the lowest index is kept; software must avoid that case.
  always_comb begin
    logic [LVL_W+GRP_W-1:0] best;
    best = '0;
    win_valid = 1'b0;
    win_idx = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig[i] && (!win_valid || ctrl[i][CTL_LVL_HI:CTL_GRP_LO] > best)) begin
        best = ctrl[i][CTL_LVL_HI:CTL_GRP_LO];
        win_valid = 1'b1;
        win_idx = IDX_W'(i);
      end
    end
    win_lvl = best[LVL_W+GRP_W-1:GRP_W];
    win_grp = best[GRP_W-1:0];
  end
endmodule

//--- ipa_core.sv
`timescale 1ns/1ps
module ipa_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  output logic instr_end
);
  logic [1:0] cnt_r;
  // A slow core ends an instruction only every fourth cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      instr_end <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      instr_end <= !slow || cnt_r == 2'h3;
    end
  end
endmodule

//--- ipa_pkg.sv
package ipa_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CTL_W = 8;
  localparam int CNT_W = 8;
  localparam int LVL_W = 4;
  localparam int GRP_W = 2;
  localparam int CHAN_W = 3;
  localparam int NUM_SRC = 16;
  localparam int NUM_CHAN = 8;

  // Register map, byte addresses, one 16-bit word each.
  localparam logic [15:0] PSW_ADDR = 16'hFF10;
  localparam logic [15:0] CNT_BASE = 16'hFEC0;
  localparam logic [15:0] CTRL_BASE = 16'hFF60;
  localparam int ADDR_STEP = 2;

  // Processor status word layout.
  localparam logic [15:0] PSW_RESET = 16'h0000;
  localparam logic [15:0] PSW_WR_MASK = 16'hFC7F;
  localparam int PSW_LVL_HI = 15;
  localparam int PSW_LVL_LO = 12;
  localparam int PSW_IEN = 11;
  localparam int PSW_HOLD = 10;

  // Source control word layout.
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int CTL_FLAG = 7;
  localparam int CTL_EN = 6;
  localparam int CTL_LVL_HI = 5;
  localparam int CTL_LVL_LO = 2;
  localparam int CTL_GRP_HI = 1;
  localparam int CTL_GRP_LO = 0;

  // Transfer count encodings.
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_CONT = 8'hFF;

  // Levels.
  localparam logic [3:0] LVL_ZERO = 4'h0;
  localparam logic [3:0] LVL_TRAP = 4'hF;
  localparam logic [2:0] LVL_XFER_TOP = 3'h7;
endpackage

//--- ipa_src.sv
`timescale 1ns/1ps
module ipa_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_set,
  input wire logic hw_clr,
  input wire logic wr_en,
  input wire logic [ipa_pkg::CTL_W-1:0] wr_data,
  output logic [ipa_pkg::CTL_W-1:0] ctrl_r
);
  import ipa_pkg::*;

  // A hardware request wins over a clear or a software write in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= CTL_RESET;
    end else begin
      if (wr_en) begin
        ctrl_r <= wr_data;
      end
      if (hw_clr) begin
        ctrl_r[CTL_FLAG] <= 1'b0;
      end
      if (req_set) begin
        ctrl_r[CTL_FLAG] <= 1'b1;
      end
    end
  end
endmodule

//--- ipa_top.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module ipa_top #(
  parameter int NUM_SRC = ipa_pkg::NUM_SRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ipa_pkg::ADDR_W-1:0] addr,
  input wire logic [ipa_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ipa_pkg::DATA_W-1:0] rd_data,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic instr_end,
  input wire logic hw_trap,
  input wire logic sw_trap,
  output logic irq_take,
  output logic [$clog2(NUM_SRC)-1:0] irq_src,
  output logic [ipa_pkg::LVL_W-1:0] irq_level,
  output logic [ipa_pkg::GRP_W-1:0] irq_group,
  output logic xfer_go,
  output logic [ipa_pkg::CHAN_W-1:0] xfer_chan,
  output logic [$clog2(NUM_SRC)-1:0] xfer_src,
  output logic stack_push,
  output logic [ipa_pkg::DATA_W-1:0] stack_data,
  output logic trap_take,
  output logic wake,
  output logic [ipa_pkg::LVL_W-1:0] cpu_level,
  output logic bus_hold_enable
);
  import ipa_pkg::*;

  localparam int IDX_W = $clog2(NUM_SRC);

  logic [CTL_W-1:0] ctrl [NUM_SRC];
  logic [NUM_SRC-1:0] ctrl_wr;
  logic [NUM_SRC-1:0] flag_clr;
  logic [NUM_CHAN-1:0] cnt_wr;
  logic [CNT_W-1:0] cnt_r [NUM_CHAN];
  logic [DATA_W-1:0] psw_r;
  logic [DATA_W-1:0] psw_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_mux;
  logic win_valid;
  logic [IDX_W-1:0] win_idx;
  logic [LVL_W-1:0] win_lvl;
  logic [GRP_W-1:0] win_grp;
  logic any_pend;
  logic [LVL_W-1:0] psw_lvl;
  logic psw_wr;
  logic accept;
  logic xfer_lvl;
  logic [CHAN_W-1:0] chan;
  logic [CNT_W-1:0] cnt_sel;
  logic [CNT_W-1:0] cnt_nxt;
  logic do_xfer;
  logic do_irq;
  logic clr_any;
  logic irq_take_r;
  logic [IDX_W-1:0] irq_src_r;
  logic [LVL_W-1:0] irq_level_r;
  logic [GRP_W-1:0] irq_group_r;
  logic xfer_go_r;
  logic [CHAN_W-1:0] xfer_chan_r;
  logic [IDX_W-1:0] xfer_src_r;
  logic stack_push_r;
  logic [DATA_W-1:0] stack_data_r;
  logic trap_take_r;
  logic wake_r;

  // Decisions use the status word as it stands before this edge.
  assign psw_lvl = psw_r[PSW_LVL_HI:PSW_LVL_LO];
  assign psw_wr = wr_en && (addr == PSW_ADDR);

  // Source control words, one cell per source.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      assign ctrl_wr[g] = wr_en && (addr == ADDR_W'(CTRL_BASE + g * ADDR_STEP));
      assign flag_clr[g] = clr_any && (win_idx == IDX_W'(g));
      ipa_src u_src (
        .clk(clk),
        .rst_n(rst_n),
        .req_set(src_req[g]),
        .hw_clr(flag_clr[g]),
        .wr_en(ctrl_wr[g]),
        .wr_data(wr_data[CTL_W-1:0]),
        .ctrl_r(ctrl[g])
      );
    end
  endgenerate

  // The arbiter is combinational; its winner is only acted on at an instruction end.
  ipa_arb #(
    .NUM_SRC(NUM_SRC),
    .IDX_W(IDX_W)
  ) u_arb (
    .ctrl(ctrl),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl),
    .win_grp(win_grp),
    .any_pend(any_pend)
  );

  // A hardware trap in the same cycle takes the CPU; the request stays pending.
  assign accept = instr_end && !hw_trap && psw_r[PSW_IEN] && win_valid && (win_lvl > psw_lvl);
  assign xfer_lvl = (win_lvl[LVL_W-1:1] == LVL_XFER_TOP);
  assign chan = {win_lvl[0], win_grp};
  // With distinct channels, level-then-group order equals channel number order.
  assign cnt_sel = cnt_r[chan];
  assign do_xfer = accept && xfer_lvl && (cnt_sel != CNT_ZERO);
  assign do_irq = accept && !do_xfer;
  // The flag survives the transfer that brings the count down to zero.
  assign clr_any = do_irq || (do_xfer && (cnt_sel != CNT_ONE));

  // Continuous mode keeps its count; any other transfer uses one up.
  always_comb begin
    cnt_nxt = cnt_sel;
    if (cnt_sel != CNT_CONT) begin
      cnt_nxt = cnt_sel - CNT_ONE;
    end
  end

  // Transfer counts, one per channel.
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      assign cnt_wr[g] = wr_en && (addr == ADDR_W'(CNT_BASE + g * ADDR_STEP));
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cnt_r[g] <= CNT_RESET;
        end else if (do_xfer && (chan == CHAN_W'(g))) begin
          cnt_r[g] <= cnt_nxt;
        end else if (cnt_wr[g]) begin
          cnt_r[g] <= wr_data[CNT_W-1:0];
        end
      end
    end
  endgenerate

  // Status word: hardware updates take precedence over a software write.
  always_comb begin
    psw_nxt = psw_r;
    if (hw_trap) begin
      psw_nxt[PSW_LVL_HI:PSW_LVL_LO] = LVL_TRAP;
    end else if (do_irq) begin
      psw_nxt[PSW_LVL_HI:PSW_LVL_LO] = win_lvl;
    end else if (psw_wr) begin
      psw_nxt = wr_data & PSW_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psw_r <= PSW_RESET;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  // Stack push of the old status word on every routine entry.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_push_r <= 1'b0;
    end else begin
      stack_push_r <= hw_trap || sw_trap || do_irq;
    end
  end

  // The pushed word is the status before this cycle's update, so a nested entry saves the outer level.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_data_r <= PSW_RESET;
    end else if (hw_trap || sw_trap || do_irq) begin
      stack_data_r <= psw_r;
    end
  end

  // Traps are taken whatever the global enable and the CPU level say.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trap_take_r <= 1'b0;
    end else begin
      trap_take_r <= hw_trap || sw_trap;
    end
  end

  // Interrupt entry request toward the core.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_take_r <= 1'b0;
    end else begin
      irq_take_r <= do_irq;
    end
  end

  // The winner's identity holds until the next entry, so the core may read it late.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_src_r <= '0;
      irq_level_r <= LVL_ZERO;
      irq_group_r <= '0;
    end else if (do_irq) begin
      irq_src_r <= win_idx;
      irq_level_r <= win_lvl;
      irq_group_r <= win_grp;
    end
  end

  // Single stolen cycle for a channel transfer; no status change.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_go_r <= 1'b0;
    end else begin
      xfer_go_r <= do_xfer;
    end
  end

  // Channel and source of the last transfer hold for the pointer logic.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_chan_r <= '0;
      xfer_src_r <= '0;
    end else if (do_xfer) begin
      xfer_chan_r <= chan;
      xfer_src_r <= win_idx;
    end
  end

  // Any enabled pending request, level zero included, ends idle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= any_pend;
    end
  end

  // Unmapped addresses read as zero, as do the unused upper bits of byte-wide words.
  always_comb begin
    rd_mux = '0;
    if (addr == PSW_ADDR) begin
      rd_mux = psw_r;
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      if (addr == ADDR_W'(CTRL_BASE + i * ADDR_STEP)) begin
        rd_mux = {{(DATA_W - CTL_W){1'b0}}, ctrl[i]};
      end
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (addr == ADDR_W'(CNT_BASE + i * ADDR_STEP)) begin
        rd_mux = {{(DATA_W - CNT_W){1'b0}}, cnt_r[i]};
      end
    end
  end

  // Read data drop back to zero outside the read cycle, so no stale word lingers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      rd_data_r <= rd_mux;
    end else begin
      rd_data_r <= '0;
    end
  end

  // Outputs are straight register copies; the core sees no combinational path.
  assign rd_data = rd_data_r;
  assign irq_take = irq_take_r;
  assign irq_src = irq_src_r;
  assign irq_level = irq_level_r;
  assign irq_group = irq_group_r;
  assign xfer_go = xfer_go_r;
  assign xfer_chan = xfer_chan_r;
  assign xfer_src = xfer_src_r;
  assign stack_push = stack_push_r;
  assign stack_data = stack_data_r;
  assign trap_take = trap_take_r;
  assign wake = wake_r;
  assign cpu_level = psw_r[PSW_LVL_HI:PSW_LVL_LO];
  assign bus_hold_enable = psw_r[PSW_HOLD];
endmodule

//--- ipa_top_monitor.sv
`timescale 1ns/1ps
module ipa_top_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [ipa_pkg::DATA_W-1:0] rd_data,
  input wire logic instr_end,
  input wire logic hw_trap,
  input wire logic sw_trap,
  input wire logic irq_take,
  input wire logic [ipa_pkg::LVL_W-1:0] irq_level,
  input wire logic xfer_go,
  input wire logic stack_push,
  input wire logic trap_take,
  input wire logic [ipa_pkg::LVL_W-1:0] cpu_level
);
  import ipa_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  svc_at_end_a: assert property ((irq_take || xfer_go) |-> $past(instr_end))
    else $error("service without instruction end");
  one_service_a: assert property (!(irq_take && xfer_go))
    else $error("interrupt and transfer together");
  irq_push_a: assert property (irq_take |-> stack_push && cpu_level == irq_level)
    else $error("entry without push or level load");
  above_cpu_a: assert property (irq_take |-> irq_level > $past(cpu_level))
    else $error("interrupt not above cpu level");
  no_level_zero_a: assert property (irq_take |-> irq_level != LVL_ZERO)
    else $error("level zero interrupt taken");
  xfer_quiet_a: assert property (xfer_go |-> $stable(cpu_level) && !stack_push)
    else $error("transfer touched cpu level");
  hw_trap_a: assert property (hw_trap |=> trap_take && !irq_take && cpu_level == LVL_TRAP)
    else $error("hardware trap not taken at top level");
  sw_trap_a: assert property (sw_trap && !hw_trap && !instr_end && !wr_en |=> trap_take ##0 $stable(cpu_level))
    else $error("software trap changed cpu level");
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data outside read cycle");
  cover property (irq_take);
  cover property (xfer_go);
  cover property (trap_take);
endmodule
bind ipa_top ipa_top_monitor ipa_top_monitor_i (.clk(clk), .rst_n(rst_n), .rd_en(rd_en), .wr_en(wr_en),
  .rd_data(rd_data), .instr_end(instr_end), .hw_trap(hw_trap), .sw_trap(sw_trap), .irq_take(irq_take),
  .irq_level(irq_level), .xfer_go(xfer_go), .stack_push(stack_push), .trap_take(trap_take),
  .cpu_level(cpu_level));

//--- tb_interrupt_priority_arbiter.sv
`timescale 1ns/1ps
module tb_interrupt_priority_arbiter;
  import ipa_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, hw_trap = 1'b0, sw_trap = 1'b0, slow = 1'b0;
  logic [15:0] addr = 16'h0000, wr_data = 16'h0000, src_req = 16'h0000, rd_data, stack_data;
  logic instr_end, irq_take, xfer_go, stack_push, trap_take, wake, bus_hold_enable;
  logic [3:0] irq_src, irq_level, xfer_src, cpu_level;
  logic [1:0] irq_group;
  logic [2:0] xfer_chan;
  logic [23:0] r;
  int error_cnt = 0;
  int tests_run = 0;
  // Row: control word, count, transfer expected, channel or level.
  logic [23:0] rows [5] = '{24'h7F0217, 24'h7A0112, 24'h7E000F, 24'h76050D, 24'h440001};
  always #2.5 clk = ~clk;
  ipa_core ipa_core_i (.clk(clk), .rst_n(rst_n), .slow(slow), .instr_end(instr_end));
  ipa_top #(.NUM_SRC(16)) ipa_top_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .src_req(src_req), .instr_end(instr_end),
    .hw_trap(hw_trap), .sw_trap(sw_trap), .irq_take(irq_take), .irq_src(irq_src), .irq_level(irq_level),
    .irq_group(irq_group), .xfer_go(xfer_go), .xfer_chan(xfer_chan), .xfer_src(xfer_src),
    .stack_push(stack_push), .stack_data(stack_data), .trap_take(trap_take), .wake(wake),
    .cpu_level(cpu_level), .bus_hold_enable(bus_hold_enable));
  task end_of_test();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk) begin
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
    end
    @(posedge clk) wr_en <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e, input string m);
    @(posedge clk) begin
      rd_en <= 1'b1;
      addr <= a;
    end
    @(posedge clk) rd_en <= 1'b0;
    #1;
    chk(rd_data === e, m);
  endtask
  task pulse(input logic [15:0] s, input logic h, input logic w);
    @(posedge clk) begin
      src_req <= s;
      hw_trap <= h;
      sw_trap <= w;
    end
    @(posedge clk) begin
      src_req <= 16'h0000;
      hw_trap <= 1'b0;
      sw_trap <= 1'b0;
    end
  endtask
  task ev();
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      #1;
      if (irq_take || xfer_go)
        break;
    end
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(PSW_ADDR, PSW_RESET, "status reset");
    chk(cpu_level === 4'h0 && wake === 1'b0, "reset outputs");
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      wr(PSW_ADDR, 16'h0000);
      wr(CNT_BASE + {12'h000, r[18:16], 1'b0}, {8'h00, r[15:8]});
      wr(CTRL_BASE, {8'h00, r[23:16]});
      pulse(16'h0001, 1'b0, 1'b0);
      wr(PSW_ADDR, 16'h0800);
      ev();
      if (r[4]) begin
        chk(xfer_go === 1'b1 && xfer_chan === r[2:0] && xfer_src === 4'h0 && cpu_level === 4'h0, "transfer");
        rd(CNT_BASE + {12'h000, r[18:16], 1'b0}, {8'h00, r[15:8] - 8'h01}, "count");
      end else begin
        chk(irq_take === 1'b1 && irq_level === r[3:0] && cpu_level === r[3:0], "interrupt");
        chk(stack_push === 1'b1 && stack_data === 16'h0800, "push");
      end
    end
    $display("table test done");
    wr(16'hFF76, 16'h0040);
    pulse(16'h0800, 1'b0, 1'b0);
    ev();
    chk(irq_take === 1'b0 && wake === 1'b1, "level zero");
    wr(16'hFF76, 16'h0000);
    $display("level zero test done");
    // Distinct group levels per level, as software must keep them.
    wr(PSW_ADDR, 16'h0000);
    wr(16'hFF70, 16'h004C);
    wr(16'hFF72, 16'h004E);
    wr(16'hFF74, 16'h004B);
    wr(16'hFF78, 16'h003C);
    pulse(16'h1700, 1'b0, 1'b0);
    ev();
    chk(irq_take === 1'b0, "held by global enable");
    slow <= 1'b1;
    wr(PSW_ADDR, 16'h0800);
    ev();
    chk(irq_take === 1'b1 && irq_src === 4'h9 && irq_group === 2'h2, "arbitration");
    ev();
    chk(irq_take === 1'b0 && cpu_level === 4'h3, "same level blocked");
    wr(PSW_ADDR, 16'h0800);
    ev();
    chk(irq_take === 1'b1 && irq_src === 4'h8, "level lowered");
    $display("arbitration test done");
    wr(PSW_ADDR, 16'h0000);
    wr(CNT_BASE + 16'h0008, 16'h0003);
    wr(CNT_BASE + 16'h0006, 16'h0003);
    wr(CTRL_BASE, 16'h007C);
    wr(CTRL_BASE + 16'h0002, 16'h007B);
    pulse(16'h0003, 1'b0, 1'b0);
    wr(PSW_ADDR, 16'h0800);
    ev();
    chk(xfer_go === 1'b1 && xfer_chan === 3'h4 && xfer_src === 4'h0, "channel order");
    ev();
    chk(xfer_go === 1'b1 && xfer_chan === 3'h3 && xfer_src === 4'h1, "second channel");
    $display("channel test done");
    wr(PSW_ADDR, 16'h0000);
    pulse(16'h0000, 1'b1, 1'b0);
    #1;
    chk(trap_take === 1'b1 && stack_push === 1'b1 && cpu_level === 4'hF, "hw trap");
    wr(PSW_ADDR, 16'h5000);
    pulse(16'h0000, 1'b0, 1'b1);
    #1;
    chk(trap_take === 1'b1 && cpu_level === 4'h5, "sw trap");
    $display("trap test done");
    wr(PSW_ADDR, 16'hFFFF);
    rd(PSW_ADDR, PSW_WR_MASK, "status access");
    chk(bus_hold_enable === 1'b1 && cpu_level === 4'hF, "status fields");
    rd(16'hFF12, 16'h0000, "unmapped read");
    $display("register test done");
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(cpu_level === 4'h0 && bus_hold_enable === 1'b0 && wake === 1'b0, "mid-run reset");
    rd(PSW_ADDR, PSW_RESET, "status after reset");
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
